// ---- etp_pkg.sv ----
// constants and types for the emulation and test pin control block
package etp_pkg;
   // synchroniser vector bit positions
   localparam int SY_TCK  = 0;
   localparam int SY_TDI  = 1;
   localparam int SY_TMS  = 2;
   localparam int SY_SECOND_MODE_SELECT = 3;
   localparam int SY_TRST = 4;
   localparam int SY_EMULATOR_PIN_ZERO = 5;
   localparam int SY_EMU1 = 6;
   localparam int SY_BIO  = 7;
   localparam int SY_W    = 8;

   localparam int IR_W  = 4;
   localparam int EDR_W = 2;
   localparam logic [IR_W-1:0]  IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0]  IR_BYPASS  = 4'hf;
   localparam logic [IR_W-1:0]  IR_EMUCTL  = 4'h2;
   localparam logic [EDR_W-1:0] EDR_RESET  = 2'h0;
   localparam int EDR_EMULATOR_PIN_ZERO_DIR = 0;
   localparam int EDR_EMU1_DIR = 1;

   // strap is caught one cycle after the counter reaches this, past the two-stage sync
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } etp_tap_e;

   typedef struct packed {
      logic [SY_W-1:0]  sy1;
      logic [SY_W-1:0]  sy2;
      logic             tck_prev;
      etp_tap_e         tap;
      logic [IR_W-1:0]  ir;
      logic [IR_W-1:0]  ir_sh;
      logic [EDR_W-1:0] edr_sh;
      logic [EDR_W-1:0] emu_ctl;
      logic             byp;
      logic             tdo;
      logic             tdo_oe;
      logic             second_mode_select;
      logic [1:0]       strap_cnt;
      logic             strap_done;
      logic             pll_byp;
      logic             off;
      logic             emulator_pin_zero_o;
      logic             emulator_pin_zero_oe;
      logic             emu1_o;
      logic             emu1_oe;
      logic             emulator_pin_zero_irq;
      logic             emu1_irq;
      logic             bio_gpio;
      logic             gpio_dir;
      logic             gpio_val;
      logic             gpio_oe;
      logic             br_taken;
      logic             br_done;
   } etp_state_s;
endpackage : etp_pkg

// ---- etp_top.sv ----
// emulation/test pin control: tap, emulator pins, outputs-off, branch pin
//
// Overview of operation
// RQ1: tdi shifts into the selected instruction or data register on tck rise.
// RQ2: selected register's bit drives tdo on each tck fall.
// RQ3: tms is sampled into the tap state machine on tck rise.
// RQ4: second mode select is also sampled on tck rise, test use only.
// RQ5: test reset high gives scan control; low holds tap reset, functional.
// RQ6: with test reset high, emulator pin zero is a scan-directed interrupt.
// RQ7: with test reset high, emulator pin one is a scan-directed interrupt.
// RQ8: with test reset low, pin one low turns every output driver off.
// RQ9: outside party holds test reset 0, pin zero 1, pin one 0 for off.
// RQ10: polled branch is taken when branch input low, else falls through.
// RQ11: every reset makes the shared pin the branch input; software may remap.
// RQ12: board should hold an unused branch input high.
// RQ13: mode select, second select and test reset low at reset pick bypass.
// RQ14: after reset the general-purpose pin is an input until reprogrammed.
// RQ15: tap, instruction and bypass registers follow standard tap sequencing.
module etp_top
   import etp_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic rstn_in,
   input  wire logic tck_in,
   input  wire logic tdi_in,
   input  wire logic tms_in,
   input  wire logic second_mode_select_in,
   input  wire logic test_reset_in,
   output logic      tdo_out,
   output logic      tdo_oe_out,
   input  wire logic emulator_pin_zero_in,
   output logic      emulator_pin_zero_out,
   output logic      emulator_pin_zero_oe_out,
   input  wire logic emulator_pin_one_outputs_off_in,
   output logic      emulator_pin_one_outputs_off_out,
   output logic      emulator_pin_one_outputs_off_oe_out,
   input  wire logic emu_irq_req_in,
   output logic      emulator_pin_zero_irq_out,
   output logic      emu1_irq_out,
   output logic      outputs_off_out,
   output logic      scan_control_out,
   output logic      second_select_out,
   output logic      pll_bypass_out,
   input  wire logic branch_control_input_in,
   output logic      port_c_bit_one_io_out,
   output logic      port_c_bit_one_io_oe_out,
   input  wire logic pin_gpio_mode_in,
   input  wire logic gpio_dir_wr_in,
   input  wire logic gpio_dir_in,
   input  wire logic gpio_val_wr_in,
   input  wire logic gpio_val_in,
   input  wire logic conditional_branch_instruction_in,
   output logic      branch_taken_out,
   output logic      branch_done_out
);

   etp_state_s q;
   etp_state_s d;

   function automatic etp_tap_e tap_next(input etp_tap_e s,
                                         input logic     m);
      unique case (s)
         TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction : tap_next

   logic tck_rise;
   logic tck_fall;
   logic trst_s;
   logic sel_emu;

   always_comb begin
      tck_rise = q.sy2[SY_TCK] & ~q.tck_prev;
      tck_fall = ~q.sy2[SY_TCK] & q.tck_prev;
      trst_s   = q.sy2[SY_TRST];
      sel_emu  = (q.ir == IR_EMUCTL);
   end

   always_comb begin
      d = q;
      d.sy1 = {branch_control_input_in, emulator_pin_one_outputs_off_in,
               emulator_pin_zero_in, test_reset_in, second_mode_select_in,
               tms_in, tdi_in, tck_in};
      d.sy2 = q.sy1;
      d.tck_prev = q.sy2[SY_TCK];

      if (!trst_s) begin
         // functional mode: scan logic parked, scan pins ignored
         d.tap     = TAP_RESET; // RQ5
         d.ir      = IR_BYPASS; // RQ15
         d.emu_ctl = EDR_RESET;
      end else if (tck_rise) begin
         d.tap  = tap_next(q.tap, q.sy2[SY_TMS]); // RQ3 RQ15
         d.second_mode_select = q.sy2[SY_SECOND_MODE_SELECT]; // RQ4
         unique case (q.tap)
            TAP_RESET:  d.ir = IR_BYPASS; // RQ15
            TAP_CAP_IR: d.ir_sh = IR_CAPTURE;
            TAP_SH_IR:  d.ir_sh = {q.sy2[SY_TDI], q.ir_sh[IR_W-1:1]}; // RQ1
            TAP_UPD_IR: d.ir = q.ir_sh;
            TAP_CAP_DR: begin
               d.edr_sh = q.emu_ctl;
               d.byp    = 1'b0; // RQ15
            end
            TAP_SH_DR: begin
               if (sel_emu)
                  d.edr_sh = {q.sy2[SY_TDI], q.edr_sh[EDR_W-1:1]}; // RQ1
               else
                  d.byp = q.sy2[SY_TDI]; // RQ1
            end
            TAP_UPD_DR: if (sel_emu) d.emu_ctl = q.edr_sh; // RQ6 RQ7
            default: ;
         endcase
      end else if (tck_fall) begin
         // tdo changes only on the falling edge so the probe samples it
         // cleanly on the next rising edge
         d.tdo_oe = (q.tap == TAP_SH_IR) || (q.tap == TAP_SH_DR); // RQ2
         if (q.tap == TAP_SH_IR)
            d.tdo = q.ir_sh[0]; // RQ2
         else if (sel_emu)
            d.tdo = q.edr_sh[0]; // RQ2
         else
            d.tdo = q.byp; // RQ2
      end
      if (!trst_s)
         d.tdo_oe = 1'b0;

      // outputs-off only while test reset low, pin zero high, pin one low
      d.off = !trst_s && q.sy2[SY_EMULATOR_PIN_ZERO] && !q.sy2[SY_EMU1]; // RQ8 RQ9

      // emulator pins as interrupts; direction comes from the scan register
      d.emulator_pin_zero_o   = emu_irq_req_in;
      d.emu1_o   = emu_irq_req_in;
      d.emulator_pin_zero_oe  = trst_s && q.emu_ctl[EDR_EMULATOR_PIN_ZERO_DIR] && !d.off; // RQ6
      d.emu1_oe  = trst_s && q.emu_ctl[EDR_EMU1_DIR] && !d.off; // RQ7
      d.emulator_pin_zero_irq = trst_s && !q.emu_ctl[EDR_EMULATOR_PIN_ZERO_DIR] && q.sy2[SY_EMULATOR_PIN_ZERO];
      d.emu1_irq = trst_s && !q.emu_ctl[EDR_EMU1_DIR] && q.sy2[SY_EMU1];

      // strap: synchronisers need a few cycles after release to be valid
      if (!q.strap_done) begin
         if (q.strap_cnt == STRAP_WAIT) begin
            d.strap_done = 1'b1;
            d.pll_byp = !q.sy2[SY_SECOND_MODE_SELECT] && !q.sy2[SY_TMS] && !trst_s; // RQ13
         end else begin
            d.strap_cnt = q.strap_cnt + 2'h1;
         end
      end

      d.bio_gpio = pin_gpio_mode_in; // RQ11
      if (gpio_dir_wr_in)
         d.gpio_dir = gpio_dir_in; // RQ14
      if (gpio_val_wr_in)
         d.gpio_val = gpio_val_in;
      d.gpio_oe = d.bio_gpio && d.gpio_dir && !d.off; // RQ14 RQ8
      if (d.off)
         d.tdo_oe = 1'b0; // RQ8

      d.br_done = conditional_branch_instruction_in;
      if (conditional_branch_instruction_in)
         // a remapped pin is masked out, so the branch falls through
         d.br_taken = !q.bio_gpio && !q.sy2[SY_BIO]; // RQ10 RQ12
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q            <= '0;
         q.tap        <= TAP_RESET;
         q.ir         <= IR_BYPASS;
         q.emu_ctl    <= EDR_RESET;
         q.bio_gpio   <= 1'b0; // RQ11
         q.gpio_dir   <= 1'b0; // RQ14
      end else begin
         q <= d;
      end
   end

   assign tdo_out                             = q.tdo;
   assign tdo_oe_out                          = q.tdo_oe;
   assign emulator_pin_zero_out               = q.emulator_pin_zero_o;
   assign emulator_pin_zero_oe_out            = q.emulator_pin_zero_oe;
   assign emulator_pin_one_outputs_off_out    = q.emu1_o;
   assign emulator_pin_one_outputs_off_oe_out = q.emu1_oe;
   assign emulator_pin_zero_irq_out                        = q.emulator_pin_zero_irq;
   assign emu1_irq_out                        = q.emu1_irq;
   assign outputs_off_out                     = q.off;
   assign scan_control_out                    = q.sy2[SY_TRST];
   assign second_select_out                   = q.second_mode_select;
   assign pll_bypass_out                      = q.pll_byp;
   assign port_c_bit_one_io_out               = q.gpio_val;
   assign port_c_bit_one_io_oe_out            = q.gpio_oe;
   assign branch_taken_out                    = q.br_taken;
   assign branch_done_out                     = q.br_done;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   a_tdi_capture: assert property ( // RQ1
      tck_rise && trst_s && q.tap == TAP_SH_DR && !sel_emu
      |=> q.byp == $past(q.sy2[SY_TDI]))
      else $error("bypass bit did not take tdi on tck rise");

   a_tdo_on_fall: assert property ( // RQ2
      $changed(tdo_out) |-> $past(tck_fall) || $past(!trst_s))
      else $error("tdo changed away from a tck fall");

   a_tms_sample: assert property ( // RQ3
      tck_rise && trst_s && q.tap == TAP_RESET && !q.sy2[SY_TMS]
      |=> q.tap == TAP_IDLE ##1 q.tap == TAP_IDLE [*1])
      else $error("tap did not leave reset on tms low");

   a_second_select: assert property ( // RQ4
      tck_rise && trst_s |=> second_select_out == $past(q.sy2[SY_SECOND_MODE_SELECT]))
      else $error("second mode select not sampled on tck rise");

   a_func_mode: assert property ( // RQ5
      !trst_s |=> q.tap == TAP_RESET && !tdo_oe_out)
      else $error("scan logic active with test reset low");

   a_emu_dir: assert property ( // RQ6
      trst_s && q.emu_ctl[EDR_EMULATOR_PIN_ZERO_DIR] |=> emulator_pin_zero_oe_out
      || outputs_off_out)
      else $error("pin zero not driven though scan set output");

   a_emulator_pin_one_outputs_off_mode: assert property ( // RQ7
      !trst_s |=> !emulator_pin_one_outputs_off_oe_out)
      else $error("pin one driven while it serves as off input");

   a_outputs_off: assert property ( // RQ8
      outputs_off_out |-> !tdo_oe_out && !port_c_bit_one_io_oe_out
      && !emulator_pin_zero_oe_out && !emulator_pin_one_outputs_off_oe_out)
      else $error("a driver stayed on during outputs off");

   a_branch_poll: assert property ( // RQ10
      conditional_branch_instruction_in && !q.bio_gpio
      |=> branch_taken_out == !$past(q.sy2[SY_BIO]) && branch_done_out)
      else $error("branch decision does not follow branch input");

   a_strap_hold: assert property ( // RQ13
      q.strap_done |=> q.strap_done && $stable(pll_bypass_out))
      else $error("bypass strap changed after it was caught");

   a_gpio_input: assert property ( // RQ14
      !q.gpio_dir |-> ##1 !port_c_bit_one_io_oe_out || $past(gpio_dir_wr_in))
      else $error("gpio driven without direction set");

   a_ir_capture: assert property ( // RQ15
      tck_rise && trst_s && q.tap == TAP_CAP_IR |=> q.ir_sh == IR_CAPTURE)
      else $error("instruction register did not capture its fixed code");

   a_ir_shift: assert property ( // RQ1
      tck_rise && trst_s && q.tap == TAP_SH_IR
      |=> q.ir_sh[IR_W-1] == $past(q.sy2[SY_TDI]))
      else $error("instruction shift did not take tdi on tck rise");

   a_ir_update: assert property ( // RQ15
      tck_rise && trst_s && q.tap == TAP_UPD_IR |=> q.ir == $past(q.ir_sh))
      else $error("instruction not loaded in update state");

   a_tdo_drive: assert property ( // RQ2
      tck_fall && trst_s && q.tap == TAP_SH_DR |=> tdo_oe_out)
      else $error("tdo not enabled in data shift");

   a_tdo_bypass: assert property ( // RQ2
      tck_fall && trst_s && q.tap == TAP_SH_DR && !sel_emu
      |=> tdo_out == $past(q.byp))
      else $error("tdo does not show the bypass bit");

   a_pin0_irq: assert property ( // RQ6
      trst_s && !q.emu_ctl[EDR_EMULATOR_PIN_ZERO_DIR]
      |=> emulator_pin_zero_irq_out == $past(q.sy2[SY_EMULATOR_PIN_ZERO]))
      else $error("pin zero interrupt does not follow the pin");

   a_pin1_irq: assert property ( // RQ7
      trst_s && !q.emu_ctl[EDR_EMU1_DIR]
      |=> emu1_irq_out == $past(q.sy2[SY_EMU1]))
      else $error("pin one interrupt does not follow the pin");

   a_off_decode: assert property ( // RQ8
      !trst_s && q.sy2[SY_EMULATOR_PIN_ZERO] && !q.sy2[SY_EMU1] |=> outputs_off_out)
      else $error("outputs off not entered");

   a_branch_remap: assert property ( // RQ11
      conditional_branch_instruction_in && q.bio_gpio
      |=> !branch_taken_out && branch_done_out)
      else $error("branch taken while the pin serves as gpio");

endmodule : etp_top

// ---- etp_emu_model.sv ----
// scan emulator model driving the link pins and both emulator pins
module etp_emu_model (
   output logic      tck_out,
   output logic      tdi_out,
   output logic      tms_out,
   output logic      second_mode_select_out,
   output logic      trst_out,
   output logic      e0_oe_out,
   output logic      e0_out,
   output logic      e1_oe_out,
   output logic      e1_out,
   input  wire logic tdo_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {tck_out, tdi_out, tms_out, second_mode_select_out, trst_out} = 5'h08;
      {e0_oe_out, e0_out, e1_oe_out, e1_out} = 4'h0;
   end

   // strap levels are held across reset so the device can latch them
   task automatic pins(input logic trst, input logic second_mode_select, input logic tms);
      trst_out = trst;
      second_mode_select_out = second_mode_select;
      tms_out  = tms;
   endtask : pins

   // off needs pin zero high and pin one low together, released is pull-up
   task automatic emu(input logic o0, input logic v0, input logic o1,
                      input logic v1);
      {e0_oe_out, e0_out, e1_oe_out, e1_out} = {o0, v0, o1, v1};
   endtask : emu

   // tck stands low between frames; tms and tdi move just after the fall
   task automatic scan(input logic [15:0] tm, input logic [15:0] di,
                       output logic [15:0] dout);
      dout = 16'h0;
      // idle gap so a new frame never retouches a pin in the same step
      #80;
      for (int i = 0; i < 16; i++) begin
         tms_out = tm[i];
         tdi_out = di[i];
         #80 tck_out = 1'b1;
         dout[i] = tdo_in;
         #80 tck_out = 1'b0;
      end
      tdi_out = 1'b1;
   endtask : scan
endmodule : etp_emu_model

// ---- etp_top_test.sv ----
// self-checking bench for the emulation and test pin control block
module etp_top_test
   import etp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, irq_req, branch_control_input, gmode, dwr, dv, vwr, vv, poll;
   logic tck, tdi, tms, second_mode_select, trst, e0oe, e0, e1oe, e1;
   logic tdo, tdo_oe, p0o, p0oe, p1o, p1oe, i0, i1, off, sc, ss, pllb;
   logic pco, pcoe, btk, bdn;
   logic [15:0] d;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   // pins with pull-ups read high when nobody drives; tdo pulls low
   wire logic p0 = p0oe ? p0o : (e0oe ? e0 : 1'b1);
   wire logic p1 = p1oe ? p1o : (e1oe ? e1 : 1'b1);
   wire logic tdo_pin = tdo_oe ? tdo : 1'b0;

   etp_top dut (.mclk_in(mclk), .rstn_in(rstn), .tck_in(tck), .tdi_in(tdi),
      .tms_in(tms), .second_mode_select_in(second_mode_select), .test_reset_in(trst),
      .tdo_out(tdo), .tdo_oe_out(tdo_oe), .emulator_pin_zero_in(p0),
      .emulator_pin_zero_out(p0o), .emulator_pin_zero_oe_out(p0oe),
      .emulator_pin_one_outputs_off_in(p1),
      .emulator_pin_one_outputs_off_out(p1o),
      .emulator_pin_one_outputs_off_oe_out(p1oe), .emu_irq_req_in(irq_req),
      .emulator_pin_zero_irq_out(i0), .emu1_irq_out(i1), .outputs_off_out(off),
      .scan_control_out(sc), .second_select_out(ss), .pll_bypass_out(pllb),
      .branch_control_input_in(branch_control_input), .port_c_bit_one_io_out(pco),
      .port_c_bit_one_io_oe_out(pcoe), .pin_gpio_mode_in(gmode),
      .gpio_dir_wr_in(dwr), .gpio_dir_in(dv), .gpio_val_wr_in(vwr),
      .gpio_val_in(vv), .conditional_branch_instruction_in(poll),
      .branch_taken_out(btk), .branch_done_out(bdn));

   etp_emu_model em (.tck_out(tck), .tdi_out(tdi), .tms_out(tms),
      .second_mode_select_out(second_mode_select), .trst_out(trst), .e0_oe_out(e0oe), .e0_out(e0),
      .e1_oe_out(e1oe), .e1_out(e1), .tdo_in(tdo_pin));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // the scan is long, so ten thousand cycles is ample headroom
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 10000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic do_reset();
      rstn = 1'b0;
      tick(10);
      rstn = 1'b1;
      tick(6);
   endtask : do_reset

   task automatic ir(input logic [3:0] c);
      em.scan(16'h0306, {7'h0, c, 5'h0}, d);
      chk("ir capture", d[8:5], 4'h1);
   endtask : ir

   task automatic t_strap();
      chk("scan control low", sc, 1'b0);
      chk("pll bypass", pllb, 1'b1);
      chk("gpio oe", pcoe, 1'b0);
      em.pins(1'b0, 1'b0, 1'b1);
      do_reset();
      chk("pll bypass high tms", pllb, 1'b0);
      $display("test strap done");
   endtask : t_strap

   task automatic t_branch();
      for (int b = 0; b < 3; b++) begin
         branch_control_input = b[0];
         gmode = b[1];
         tick(4);
         poll = 1'b1;
         tick(1);
         poll = 1'b0;
         chk("branch done", bdn, 1'b1);
         chk("branch taken", btk, (b == 0));
         tick(1);
         chk("done pulse", bdn, 1'b0);
      end
      branch_control_input = 1'b1;
      $display("test branch done");
   endtask : t_branch

   task automatic t_off();
      {dwr, dv, vwr, vv} = 4'hf;
      tick(1);
      {dwr, vwr} = 2'h0;
      tick(2);
      chk("gpio oe", pcoe, 1'b1);
      chk("gpio val", pco, 1'b1);
      em.emu(1'b0, 1'b0, 1'b1, 1'b0);
      tick(4);
      chk("off", off, 1'b1);
      chk("gpio oe off", pcoe, 1'b0);
      chk("tdo oe off", tdo_oe, 1'b0);
      em.emu(1'b1, 1'b0, 1'b1, 1'b0);
      tick(4);
      chk("off pin zero low", off, 1'b0);
      em.emu(1'b0, 1'b0, 1'b0, 1'b0);
      tick(4);
      chk("off released", off, 1'b0);
      chk("gpio oe back", pcoe, 1'b1);
      $display("test outputs off done");
   endtask : t_off

   task automatic t_scan();
      // test reset low: tap parked, tdo released and pulled low
      em.scan(16'h0306, {7'h0, IR_EMUCTL, 5'h0}, d);
      chk("refused ir", d[8:5], 4'h0);
      em.scan(16'h0031, 16'h0018, d);
      chk("refused pin oe", p0oe, 1'b0);
      em.pins(1'b1, 1'b0, 1'b0);
      tick(4);
      chk("scan control", sc, 1'b1);
      chk("held tap pin oe", p0oe, 1'b0);
      irq_req = 1'b1;
      ir(IR_EMUCTL);
      chk("second select low", ss, 1'b0);
      em.scan(16'h0031, 16'h0018, d);
      tick(4);
      chk("pin0 oe", p0oe, 1'b1);
      chk("pin1 oe", p1oe, 1'b1);
      chk("pin0 out", p0o, 1'b1);
      chk("pin1 out", p1o, 1'b1);
      em.scan(16'h0031, 16'h0000, d);
      for (int v = 1; v >= 0; v--) begin
         em.emu(1'b1, v[0], 1'b1, v[0]);
         tick(4);
         chk("pin0 irq", i0, v[0]);
         chk("pin1 irq", i1, v[0]);
      end
      em.emu(1'b0, 1'b0, 1'b0, 1'b0);
      ir(IR_BYPASS);
      em.scan(16'h0061, 16'h0028, d);
      chk("bypass tdo", d[5:3], 3'h2);
      em.pins(1'b1, 1'b1, 1'b0);
      em.scan(16'h0000, 16'hffff, d);
      chk("second select", ss, 1'b1);
      $display("test scan done");
   endtask : t_scan

   initial begin
      {rstn, irq_req, gmode, dwr, dv, vwr, vv, poll} = 8'h00;
      branch_control_input = 1'b1;
      do_reset();
      t_strap();
      t_branch();
      t_off();
      t_scan();
      test_done();
   end
endmodule : etp_top_test
